// >>> sim/ahb_host.sv
// AHB-Lite host model: single whole-word transfers to the event status block.
// Assumes hready is the one slave's hreadyout and everything runs on mclk.
`timescale 1ns/1ps

module ahb_host (
    input wire logic mclk,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end

    // Address phase held until hready is seen high at an edge
    task automatic addrPhase(input logic [31:0] a, input logic w);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        haddr <= ~a;
    endtask

    // Released data is inverted so a stale value can never pass as fresh
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        addrPhase(a, 1'b1);
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        hwdata <= ~d;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        addrPhase(a, 1'b0);
        do @(posedge mclk); while (hready !== 1'b1);
        d = hrdata;
    endtask
endmodule

// >>> sim/event_status_and_stack_sizing_tb.sv
// Self-checking bench for the event status block.
// Assumes the AHB host model drives the bus and the bench drives engine pulses.
`timescale 1ns/1ps
`include "evt_defs.svh"

module event_status_and_stack_sizing_tb
    import evt_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam logic [31:0] STAT = 32'(`STAT_IDX) * 4;
    localparam logic [31:0] CFG3 = 32'(`CFG3_IDX) * 4;
    localparam logic [31:0] IEN = 32'(`IEN_IDX) * 4;
    localparam logic [31:0] CFG2 = 32'(`CFG2_IDX) * 4;
    // Mode, control-word enable, event index, expected status
    localparam logic [23:0] EV_TABLE [20] = '{24'h004000, 24'h012000, 24'h021000,
        24'h420000, 24'h431000, 24'h040800, 24'h050400, 24'h060200, 24'h070100,
        24'h080040, 24'h090020, 24'h2a0011, 24'h0a0001, 24'h0b0008, 24'h0c0004,
        24'h0d0004, 24'h0e0004, 24'h0f0002, 24'h500002, 24'h910002};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [17:0] ev = 18'h0;
    op_mode_type opMode = MODE_BC;
    logic eomEn = 1'b0;
    logic [4:0] termAddr = 5'h00;
    logic termAddrPar = 1'b1;
    logic hsel, hwrite, hreadyout, hresp, irqOut, enhanced_mode_enable;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, cmd_stack_size_sel, mon_cmd_stack_size_sel;
    logic [2:0] hsize;
    logic [11:0] cmdStackWords;
    logic [14:0] monStackWords;
    int failCount = 0;
    int nCompared = 0;
    int cycles = 0;

    always #50 mclk = ~mclk;

    ahb_host ahb_host_inst (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata));

    event_status_and_stack_sizing event_status_and_stack_sizing_inst (.mclk(mclk),
        .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .opMode(opMode),
        .ramParityErr(ev[0]), .txTimeout(ev[1]), .bcStackWrap(ev[2]),
        .rtStackWrap(ev[3]), .monCmdStackWrap(ev[4]), .monDataStackWrap(ev[5]),
        .extRamHandshakeFail(ev[6]), .bcRetry(ev[7]), .timetagWrap(ev[8]),
        .circBufferWrap(ev[9]), .msgDone(ev[10]), .ctrlWordEomEn(eomEn),
        .frameDone(ev[11]), .msgError(ev[12]), .loopbackFail(ev[13]),
        .respTimeout(ev[14]), .bcStatusMismatch(ev[15]), .rtModeCmd(ev[16]),
        .monTriggerMatch(ev[17]), .termAddr(termAddr), .termAddrPar(termAddrPar),
        .irqOut(irqOut), .enhanced_mode_enable(enhanced_mode_enable),
        .cmd_stack_size_sel(cmd_stack_size_sel),
        .mon_cmd_stack_size_sel(mon_cmd_stack_size_sel),
        .cmdStackWords(cmdStackWords), .monStackWords(monStackWords));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rdChk(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        ahb_host_inst.rd(a, d);
        chk(what, d, exp);
    endtask

    task automatic pulse(input int idx);
        @(posedge mclk);
        ev <= 18'h1 << idx;
        @(posedge mclk);
        ev <= 18'h0;
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic resetValues;
        rdChk(STAT, 32'(`STAT_RST), "status");
        rdChk(CFG3, 32'(`CFG3_RST), "cfg3");
        rdChk(32'(`IDX_BAD) * 4, 32'h0, "unmapped");
        chk("cmdWords", 32'(cmdStackWords), 32'h100);
        chk("monWords", 32'(monStackWords), 32'h100);
        chk("irq", 32'(irqOut), 32'h0);
    endtask

    task automatic stackSizes;
        logic [31:0] w;
        for (int c = 0; c < 4; c++) begin
            w = {16'h0, 1'b1, 2'(c), 2'(3 - c), 11'h0};
            ahb_host_inst.wr(CFG3, w);
            rdChk(CFG3, w, "cfg3");
            chk("enh", 32'(enhanced_mode_enable), 32'h1);
            chk("cmdWords", 32'(cmdStackWords), 32'h100 << c);
            chk("monWords", 32'(monStackWords), 32'h100 << (2 * (3 - c)));
        end
        // Enhanced mode stays on: the RT mode command flag depends on it
        ahb_host_inst.wr(CFG3, 32'h8000);
    endtask

    // Every event with all interrupt enables off; the BC stack wrap is also checked in RT mode
    task automatic eventTable;
        foreach (EV_TABLE[i]) begin
            opMode <= op_mode_type'(EV_TABLE[i][23:22]);
            eomEn <= EV_TABLE[i][21];
            pulse(int'(EV_TABLE[i][20:16]));
            rdChk(STAT, 32'(EV_TABLE[i][15:0]), "status");
            chk("irqMasked", 32'(irqOut), 32'h0);
            ahb_host_inst.wr(STAT, 32'hffff);
        end
    endtask

    task automatic irqPath;
        ahb_host_inst.wr(IEN, 32'h0001);
        ahb_host_inst.wr(CFG2, 32'h8000);
        pulse(11);
        rdChk(STAT, 32'h0008, "maskedStatus");
        chk("irqOff", 32'(irqOut), 32'h0);
        ahb_host_inst.wr(STAT, 32'hffff);
        eomEn <= 1'b0;
        pulse(10);
        rdChk(STAT, 32'h8001, "masterFlag");
        chk("irqOn", 32'(irqOut), 32'h1);
        ahb_host_inst.wr(STAT, 32'hffff);
        rdChk(STAT, 32'h0000, "cleared");
        chk("irqDropped", 32'(irqOut), 32'h0);
    endtask

    // Odd parity on the straps; limitation: polled, no fixed sync latency
    task automatic strapParity;
        logic [31:0] d;
        d = 32'h0;
        termAddrPar <= 1'b0;
        for (int i = 0; i < 10 && d[7] !== 1'b1; i++) ahb_host_inst.rd(STAT, d);
        chk("parityFault", d & 32'h80, 32'h80);
        termAddrPar <= 1'b1;
        for (int i = 0; i < 4; i++) ahb_host_inst.rd(STAT, d);
        ahb_host_inst.wr(STAT, 32'hffff);
        rdChk(STAT, 32'h0000, "parityClear");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and timeout
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        resetValues;
        stackSizes;
        eventTable;
        irqPath;
        strapParity;
        tally_and_finish;
    end
endmodule

// >>> src/event_status_and_stack_sizing.sv
// Event status register, interrupt request and stack sizing fields.
// Assumes event inputs are one-cycle pulses from engines on mclk and
// terminal address straps arrive asynchronously from pins.
`timescale 1ns/1ps
`include "evt_defs.svh"

module event_status_and_stack_sizing
    import evt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Engine events
    input wire op_mode_type opMode,
    input wire logic ramParityErr,
    input wire logic txTimeout,
    input wire logic bcStackWrap,
    input wire logic rtStackWrap,
    input wire logic monCmdStackWrap,
    input wire logic monDataStackWrap,
    input wire logic extRamHandshakeFail,
    input wire logic bcRetry,
    input wire logic timetagWrap,
    input wire logic circBufferWrap,
    input wire logic msgDone,
    input wire logic ctrlWordEomEn,
    input wire logic frameDone,
    input wire logic msgError,
    input wire logic loopbackFail,
    input wire logic respTimeout,
    input wire logic bcStatusMismatch,
    input wire logic rtModeCmd,
    input wire logic monTriggerMatch,
    // Strapped terminal address and parity pins
    input wire logic [4:0] termAddr,
    input wire logic termAddrPar,
    // Outputs
    output logic irqOut,
    output logic enhanced_mode_enable,
    output logic [1:0] cmd_stack_size_sel,
    output logic [1:0] mon_cmd_stack_size_sel,
    output logic [11:0] cmdStackWords,
    output logic [14:0] monStackWords
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    reg_word_type stat_r;
    reg_word_type statNxt;
    reg_word_type cfg3_r;
    reg_word_type cfg3Nxt;
    reg_word_type ien_r;
    reg_word_type ienNxt;
    reg_word_type cfg2_r;
    reg_word_type cfg2Nxt;
    reg_word_type setVec;
    logic [7:0] addrIdx;
    logic [7:0] wrIdx_r;
    logic wrPend_r;
    logic addrPhase;
    logic wrNow;
    logic irqReq;
    logic enhIrq;
    logic stackWrap;
    logic modeEvent;
    logic [5:0] strapMeta_r;
    logic [5:0] strapSync_r;
    logic [1:0] strapFill_r;
    logic addrParityFault;
    logic [31:0] rdNxt;
    logic [31:0] hrdata_r;
    logic irqOut_r;
    logic [11:0] cmdWords_r;
    logic [14:0] monWords_r;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------

    // Stalling while ce is low keeps a data phase from being lost
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    assign addrPhase = hsel && htrans[1] && hready && ce;
    assign addrIdx = (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'b00)
                     ? haddr[9:2] : `IDX_BAD;
    assign wrNow = wrPend_r && ce;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrIdx_r <= 8'h00;
        end else if (ce) begin
            wrPend_r <= addrPhase && hwrite;
            wrIdx_r <= addrIdx;
        end
    end

    // Read data is taken from next values so a write just ahead is seen
    always_comb begin
        rdNxt = 32'h00000000;
        unique case (addrIdx)
            `STAT_IDX: rdNxt = {16'h0000, statNxt};
            `CFG3_IDX: rdNxt = {16'h0000, cfg3Nxt};
            `IEN_IDX: rdNxt = {16'h0000, ienNxt};
            `CFG2_IDX: rdNxt = {16'h0000, cfg2Nxt};
            default: rdNxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hrdata_r <= 32'h00000000;
        end else if (ce && addrPhase && !hwrite) begin
            hrdata_r <= rdNxt;
        end
    end

    // ------------------------------------------------------------
    // Strap synchroniser and parity check
    // ------------------------------------------------------------

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            strapMeta_r <= 6'h00;
            strapSync_r <= 6'h00;
            strapFill_r <= 2'b00;
        end else if (ce) begin
            strapMeta_r <= {termAddrPar, termAddr};
            strapSync_r <= strapMeta_r;
            strapFill_r <= {strapFill_r[0], 1'b1};
        end
    end

    // Checked only once the synchroniser holds real pin values
    assign addrParityFault = strapFill_r[1] && !(^strapSync_r);

    // ------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------

    assign enhIrq = cfg2_r[`ENHIRQ_BIT];

    always_comb begin
        stackWrap = 1'b0;
        unique case (opMode)
            MODE_BC: stackWrap = bcStackWrap;
            MODE_RT: stackWrap = rtStackWrap;
            MODE_MT: stackWrap = 1'b0;
            MODE_IDLE: stackWrap = 1'b0;
        endcase
    end

    always_comb begin
        modeEvent = 1'b0;
        unique case (opMode)
            MODE_BC: modeEvent = bcStatusMismatch;
            MODE_RT: modeEvent = rtModeCmd && enhanced_mode_enable;
            MODE_MT: modeEvent = monTriggerMatch;
            MODE_IDLE: modeEvent = 1'b0;
        endcase
    end

    // Flags set from events alone, the enable plays no part here except in the master flag
    always_comb begin
        setVec = 16'h0000;
        setVec[`PARITY_BIT] = ramParityErr;
        setVec[`TX_TIMEOUT_FLAG_BIT] = txTimeout;
        setVec[`STK_BIT] = stackWrap;
        setVec[`MONCMD_BIT] = monCmdStackWrap;
        setVec[`MONDAT_BIT] = monDataStackWrap;
        setVec[`HSK_BIT] = extRamHandshakeFail;
        setVec[`RETRY_BIT] = bcRetry;
        setVec[`TAP_BIT] = addrParityFault;
        setVec[`TTAG_BIT] = timetagWrap;
        setVec[`CIRC_BIT] = circBufferWrap;
        setVec[`CTRLWORD_MSG_DONE_FLAG_BIT] = msgDone && ctrlWordEomEn;
        setVec[`FRAME_BIT] = frameDone;
        setVec[`ERR_BIT] = msgError || loopbackFail || respTimeout;
        setVec[`MODEDEP_BIT] = modeEvent;
        setVec[`EOM_BIT] = msgDone;
        setVec[`MASTER_BIT] = irqReq && enhIrq;
    end

    assign irqReq = |(setVec[14:0] & ien_r[14:0]);

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------

    // Write one to clear; an event in the same cycle wins over the clear
    always_comb begin
        statNxt = stat_r;
        if (wrNow && wrIdx_r == `STAT_IDX) begin
            statNxt = stat_r & ~hwdata[15:0];
        end
        statNxt = statNxt | setVec;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stat_r <= `STAT_RST;
        end else if (ce) begin
            stat_r <= statNxt;
        end
    end

    // Level output: stays up while an enabled flag in bits 14:0 remains set
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqOut_r <= 1'b0;
        end else if (ce) begin
            irqOut_r <= |(statNxt[14:0] & ien_r[14:0]);
        end
    end

    assign irqOut = irqOut_r;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------

    always_comb begin
        cfg3Nxt = cfg3_r;
        if (wrNow && wrIdx_r == `CFG3_IDX) begin
            cfg3Nxt = {hwdata[15:11], 11'h000};
        end
    end

    always_comb begin
        ienNxt = ien_r;
        if (wrNow && wrIdx_r == `IEN_IDX) begin
            ienNxt = hwdata[15:0];
        end
    end

    always_comb begin
        cfg2Nxt = cfg2_r;
        if (wrNow && wrIdx_r == `CFG2_IDX) begin
            cfg2Nxt = {hwdata[15], 15'h0000};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg3_r <= `CFG3_RST;
            ien_r <= `IEN_RST;
            cfg2_r <= `CFG2_RST;
        end else if (ce) begin
            cfg3_r <= cfg3Nxt;
            ien_r <= ienNxt;
            cfg2_r <= cfg2Nxt;
        end
    end

    assign enhanced_mode_enable = cfg3_r[`ENH_BIT];
    assign cmd_stack_size_sel = cfg3_r[`CMDSZ_HI:`CMDSZ_LO];
    assign mon_cmd_stack_size_sel = cfg3_r[`MONSZ_HI:`MONSZ_LO];

    // ------------------------------------------------------------
    // Stack size decode
    // ------------------------------------------------------------

    // Command stack doubles per code, monitor stack quadruples
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmdWords_r <= `CMD_STK_BASE;
            monWords_r <= `MON_STK_BASE;
        end else if (ce) begin
            cmdWords_r <= `CMD_STK_BASE << cfg3Nxt[`CMDSZ_HI:`CMDSZ_LO];
            monWords_r <= `MON_STK_BASE << {cfg3Nxt[`MONSZ_HI:`MONSZ_LO], 1'b0};
        end
    end

    assign cmdStackWords = cmdWords_r;
    assign monStackWords = monWords_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    flag_unmasked_a: assert property (
        ce && msgDone && !ien_r[`EOM_BIT] |=> stat_r[`EOM_BIT])
        else $error("flag not set with enable low");

    master_flag_a: assert property (
        ce && irqReq && enhIrq |=> stat_r[`MASTER_BIT])
        else $error("master flag missed");

    master_quiet_a: assert property (
        ce && !enhIrq && !stat_r[`MASTER_BIT] && !(wrNow && wrIdx_r == `CFG2_IDX)
        |=> !stat_r[`MASTER_BIT])
        else $error("master flag set without enhanced interrupts");

    ram_parity_a: assert property (
        ce && ramParityErr |=> stat_r[`PARITY_BIT])
        else $error("parity flag missed");

    tx_timeout_a: assert property (
        ce && txTimeout |=> stat_r[`TX_TIMEOUT_FLAG_BIT])
        else $error("timeout flag missed");

    stack_wrap_a: assert property (
        ce && opMode == MODE_RT && rtStackWrap |=> stat_r[`STK_BIT])
        else $error("command stack wrap missed");

    mon_wrap_a: assert property (
        ce && monCmdStackWrap |=> stat_r[`MONCMD_BIT])
        else $error("monitor stack wrap missed");

    mon_data_a: assert property (
        ce && monDataStackWrap |=> stat_r[`MONDAT_BIT])
        else $error("monitor data wrap missed");

    handshake_fail_a: assert property (
        ce && extRamHandshakeFail |=> stat_r[`HSK_BIT])
        else $error("handshake flag missed");

    retry_flag_a: assert property (
        ce && bcRetry |=> stat_r[`RETRY_BIT])
        else $error("retry flag missed");

    addr_parity_a: assert property (
        ce && addrParityFault |=> stat_r[`TAP_BIT])
        else $error("address parity flag missed");

    timetag_wrap_a: assert property (
        ce && timetagWrap |=> stat_r[`TTAG_BIT])
        else $error("time tag flag missed");

    circ_wrap_a: assert property (
        ce && circBufferWrap |=> stat_r[`CIRC_BIT])
        else $error("circular buffer flag missed");

    cw_eom_a: assert property (
        ce && !stat_r[`CTRLWORD_MSG_DONE_FLAG_BIT] && !(msgDone && ctrlWordEomEn)
        |=> !stat_r[`CTRLWORD_MSG_DONE_FLAG_BIT])
        else $error("control word flag set without cause");

    frame_done_a: assert property (
        ce && frameDone |=> stat_r[`FRAME_BIT])
        else $error("frame flag missed");

    msg_error_a: assert property (
        ce && (msgError || loopbackFail || respTimeout) |=> stat_r[`ERR_BIT])
        else $error("error flag missed");

    mode_dep_a: assert property (
        ce && opMode == MODE_BC && bcStatusMismatch |=> stat_r[`MODEDEP_BIT])
        else $error("mode dependent flag missed");

    eom_flag_a: assert property (
        ce && msgDone |=> stat_r[`EOM_BIT])
        else $error("end of message flag missed");

    enh_write_a: assert property (
        wrNow && wrIdx_r == `CFG3_IDX |=> enhanced_mode_enable == $past(hwdata[15]))
        else $error("enhanced mode write lost");

    cmd_size_a: assert property (
        ce ##1 1 |-> cmdStackWords == (`CMD_STK_BASE << cmd_stack_size_sel))
        else $error("command stack size wrong");

    mon_size_a: assert property (
        ce ##1 1 |-> monStackWords == (`MON_STK_BASE << {mon_cmd_stack_size_sel, 1'b0}))
        else $error("monitor stack size wrong");

    irq_raise_a: assert property (
        ce && irqReq |=> irqOut)
        else $error("interrupt not raised");

endmodule

// >>> src/evt_defs.svh
// Offsets, field positions and reset values of the event status block.
// Assumes word addressing: byte address is four times the register index.
`ifndef EVT_DEFS_SVH
`define EVT_DEFS_SVH

// Register indices
`define STAT_IDX 8'h06
`define CFG3_IDX 8'h07
`define IEN_IDX 8'h08
`define CFG2_IDX 8'h09
`define IDX_BAD 8'hff

// Status flag positions
`define MASTER_BIT 15
`define PARITY_BIT 14
`define TX_TIMEOUT_FLAG_BIT 13
`define STK_BIT 12
`define MONCMD_BIT 11
`define MONDAT_BIT 10
`define HSK_BIT 9
`define RETRY_BIT 8
`define TAP_BIT 7
`define TTAG_BIT 6
`define CIRC_BIT 5
`define CTRLWORD_MSG_DONE_FLAG_BIT 4
`define FRAME_BIT 3
`define ERR_BIT 2
`define MODEDEP_BIT 1
`define EOM_BIT 0

// Configuration fields
`define ENH_BIT 15
`define CMDSZ_HI 14
`define CMDSZ_LO 13
`define MONSZ_HI 12
`define MONSZ_LO 11
`define ENHIRQ_BIT 15

// Stack sizes in words for code 00
`define CMD_STK_BASE 12'h100
`define MON_STK_BASE 15'h0100

// Reset values
`define STAT_RST 16'h0000
`define CFG3_RST 16'h0000
`define IEN_RST 16'h0000
`define CFG2_RST 16'h0000

`endif

// >>> src/evt_pkg.sv
// Types shared by the event status block.
// Assumes nothing beyond the defs header.
package evt_pkg;
    typedef logic [15:0] reg_word_type;
    typedef enum logic [1:0] {
        MODE_BC,
        MODE_RT,
        MODE_MT,
        MODE_IDLE
    } op_mode_type;
endpackage
